// File: core/sldc_rise_detect.sv
// rising edge detector for the comparator result, gated by a qualifier
`timescale 1ns/1ps
module sldc_rise_detect
  import sldc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic level,
  input wire logic qualify,
  output logic rise
);
  logic prev;
  logic next_prev;

  always_comb begin
    next_prev = qualify ? level : 1'b0;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end

  // prev cleared while unqualified, so a level already high at validation counts as an edge
  assign rise = qualify & level & ~prev;
endmodule

// File: core/sldc_top.sv
// supply level detector control: registers, settling timer, result edge interrupt
// ----------------------------------------
// Summary of operation
// (RULE1) enable starts measurement; valid after 2 ms
// (RULE2) irq on each result rise while valid
// (RULE3) software uses result only while valid
// (RULE4) control bits 2-0 trim, reset 000
// (RULE5) control bit 3 range; bits 7-4 zero
// (RULE6) status: result bit2, valid bit1, enable bit0
// (RULE7) enable off: analog off, no measurement
// (RULE8) software keeps threshold settings during measurement
// (RULE9) disable clears valid; re-enable restarts settling
// (RULE10) writes to read-only/reserved bits ignored
// ----------------------------------------
`timescale 1ns/1ps
module sldc_top
  import sldc_pkg::*;
#(
  // settling length in clock cycles; the default is the full 2 ms interval
  parameter int SETTLE_CYC = SLDC_SETTLE_CYC
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [SLDC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic below_threshold_flag,
  output logic detector_enable,
  output logic [2:0] threshold_trim,
  output logic threshold_range_select,
  output logic low_supply_irq
);
  // ----------------------------------------
  // bus handshake state
  // ----------------------------------------
  logic ack;
  logic next_ack;
  logic req;
  logic wr_go;
  logic rd_cap;
  logic be0;
  // ----------------------------------------
  // control register state
  // ----------------------------------------
  logic [2:0] trim;
  logic range_sel;
  logic [2:0] next_trim;
  logic next_range_sel;
  // ----------------------------------------
  // enable state
  // ----------------------------------------
  logic enable;
  logic next_enable;
  // ----------------------------------------
  // interrupt state
  // ----------------------------------------
  logic irq_pend;
  logic irq_mask;
  logic next_irq_pend;
  logic next_irq_mask;
  // ----------------------------------------
  // read data state
  // ----------------------------------------
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  // ----------------------------------------
  // measurement state
  // ----------------------------------------
  sldc_state_t state;
  sldc_state_t next_state;
  logic [SLDC_CNT_W-1:0] cnt;
  logic [SLDC_CNT_W-1:0] next_cnt;
  logic result;
  logic next_result;
  logic valid;
  logic rise;

  function automatic logic hit(input logic [SLDC_ADDR_W-1:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------
  // readback word builders
  // ----------------------------------------
  // reserved bits are always zero, so software may compare whole bytes
  function automatic logic [31:0] ctl_word(input logic [2:0] t, input logic r);
    logic [31:0] w;
    w = 32'h0;
    w[SLDC_CTL_TRIM_LSB +: SLDC_CTL_TRIM_W] = t; // [RULE4]
    w[SLDC_CTL_RANGE_BIT] = r; // [RULE5]
    return w;
  endfunction

  function automatic logic [31:0] sta_word(input logic b, input logic v, input logic e);
    logic [31:0] w;
    w = 32'h0;
    w[SLDC_STA_BELOW_BIT] = b; // [RULE6]
    w[SLDC_STA_VALID_BIT] = v; // [RULE6]
    w[SLDC_STA_ENABLE_BIT] = e; // [RULE6]
    return w;
  endfunction

  function automatic logic [31:0] flag_word(input logic f);
    logic [31:0] w;
    w = 32'h0;
    w[SLDC_IRQ_LOW_BIT] = f;
    return w;
  endfunction

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  // one wait cycle: ack rises the cycle after the request, ending the wait;
  // a master that keeps its request past that edge starts a fresh access
  assign req = (avs_read | avs_write) & ~ack;
  assign wr_go = avs_write & ack;
  assign rd_cap = avs_read & ~ack;
  assign be0 = avs_byteenable[0];

  always_comb begin
    next_ack = req;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
    end
  end

  // ----------------------------------------
  // control register: trim and range
  // ----------------------------------------
  always_comb begin
    next_trim = trim;
    next_range_sel = range_sel;
    if (wr_go && be0 && hit(avs_address, SLDC_OFS_CONTROL)) begin
      next_trim = avs_writedata[SLDC_CTL_TRIM_LSB +: SLDC_CTL_TRIM_W]; // [RULE4]
      next_range_sel = avs_writedata[SLDC_CTL_RANGE_BIT]; // [RULE5]
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trim <= SLDC_TRIM_RST; // [RULE4]
      range_sel <= SLDC_RANGE_RST; // [RULE5]
    end else begin
      trim <= next_trim;
      range_sel <= next_range_sel;
    end
  end

  // ----------------------------------------
  // detector enable
  // ----------------------------------------
  always_comb begin
    next_enable = enable;
    if (wr_go && be0 && hit(avs_address, SLDC_OFS_STATUS)) begin
      // only enable is writable here; result and valid stay hardware owned
      next_enable = avs_writedata[SLDC_STA_ENABLE_BIT]; // [RULE7] [RULE10]
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable <= SLDC_ENABLE_RST;
    end else begin
      enable <= next_enable;
    end
  end

  // ----------------------------------------
  // interrupt pending and mask
  // ----------------------------------------
  always_comb begin
    next_irq_mask = irq_mask;
    next_irq_pend = irq_pend;
    if (wr_go && be0 && hit(avs_address, SLDC_OFS_IRQ_MASK)) begin
      next_irq_mask = avs_writedata[SLDC_IRQ_LOW_BIT];
    end
    if (wr_go && be0 && hit(avs_address, SLDC_OFS_IRQ_STATUS)
        && avs_writedata[SLDC_IRQ_LOW_BIT]) begin
      next_irq_pend = 1'b0;
    end
    // a new edge beats a simultaneous write-one-to-clear, so no event is lost
    if (rise) begin
      next_irq_pend = 1'b1; // [RULE2]
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask <= SLDC_MASK_RST;
      irq_pend <= 1'b0;
    end else begin
      irq_mask <= next_irq_mask;
      irq_pend <= next_irq_pend;
    end
  end

  // ----------------------------------------
  // read data, captured in the wait cycle
  // ----------------------------------------
  // registering the word keeps it standing through the cycle waitrequest is low
  always_comb begin
    next_rdata = rdata;
    if (rd_cap) begin
      case (avs_address)
        SLDC_OFS_CONTROL: begin
          next_rdata = ctl_word(trim, range_sel);
        end
        SLDC_OFS_STATUS: begin
          // a stale result is hidden as soon as valid drops
          next_rdata = sta_word(result & valid, valid, enable); // [RULE6] [RULE9]
        end
        SLDC_OFS_IRQ_STATUS: begin
          next_rdata = flag_word(irq_pend);
        end
        SLDC_OFS_IRQ_MASK: begin
          next_rdata = flag_word(irq_mask);
        end
        default: begin
          next_rdata = 32'h0; // [RULE10]
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 32'h0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // settling timer and result capture
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_result = result;
    case (state)
      SLDC_OFF: begin
        next_cnt = '0;
        next_result = 1'b0;
        if (enable) begin
          next_state = SLDC_SETTLE; // [RULE1]
        end
      end
      SLDC_SETTLE: begin
        next_cnt = cnt + 1'b1;
        if (!enable) begin
          next_state = SLDC_OFF; // [RULE9]
        end else if (cnt == SLDC_CNT_W'(SETTLE_CYC - 2)) begin
          next_state = SLDC_VALID; // [RULE1]
        end
      end
      SLDC_VALID: begin
        next_result = enable & below_threshold_flag;
        if (!enable) begin
          next_state = SLDC_OFF; // [RULE9]
        end
      end
      default: begin
        next_state = SLDC_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= SLDC_OFF;
      cnt <= '0;
      result <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      result <= next_result;
    end
  end

  assign valid = (state == SLDC_VALID) & enable;

  sldc_rise_detect u_rise (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .level(result),
    .qualify(valid),
    .rise(rise)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign avs_readdata = rdata;
  assign detector_enable = enable; // [RULE7]
  assign threshold_trim = trim;
  assign threshold_range_select = range_sel;
  assign low_supply_irq = irq_pend & irq_mask; // [RULE2]
endmodule

// File: pkg/sldc_pkg.sv
// package: register map, field positions, reset values and timing for the supply level detector
package sldc_pkg;
  // ----------------------------------------
  // bus and register map (word aligned byte addresses)
  // ----------------------------------------
  localparam int SLDC_ADDR_W = 4;
  localparam logic [3:0] SLDC_OFS_CONTROL = 4'h0;
  localparam logic [3:0] SLDC_OFS_STATUS = 4'h4;
  localparam logic [3:0] SLDC_OFS_IRQ_STATUS = 4'h8;
  localparam logic [3:0] SLDC_OFS_IRQ_MASK = 4'hc;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SLDC_CTL_TRIM_LSB = 0;
  localparam int SLDC_CTL_TRIM_W = 3;
  localparam int SLDC_CTL_RANGE_BIT = 3;
  localparam int SLDC_STA_ENABLE_BIT = 0;
  localparam int SLDC_STA_VALID_BIT = 1;
  localparam int SLDC_STA_BELOW_BIT = 2;
  localparam int SLDC_IRQ_LOW_BIT = 0;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [2:0] SLDC_TRIM_RST = 3'h0;
  localparam logic SLDC_RANGE_RST = 1'b0;
  localparam logic SLDC_ENABLE_RST = 1'b0;
  localparam logic SLDC_MASK_RST = 1'b0;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SLDC_CLK_HZ = 100_000_000;
  localparam int SLDC_SETTLE_US = 2000;
  localparam int SLDC_SETTLE_CYC = (SLDC_CLK_HZ / 1_000_000) * SLDC_SETTLE_US;
  localparam int SLDC_CNT_W = 18;
  typedef enum logic [1:0] {SLDC_OFF, SLDC_SETTLE, SLDC_VALID} sldc_state_t;
endpackage

// File: sim/sldc_chk.sv
// checker: bus, register and detector properties
`timescale 1ns/1ps
module sldc_chk
  import sldc_pkg::*;
#(
  parameter int SETTLE_CYC = SLDC_SETTLE_CYC
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [SLDC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic detector_enable,
  input wire logic [2:0] threshold_trim,
  input wire logic threshold_range_select,
  input wire logic low_supply_irq
);
  // ----
  // cycles since enable; saturates so it never wraps
  // ----
  logic [SLDC_CNT_W-1:0] on_cnt;
  logic [SLDC_CNT_W-1:0] next_on_cnt;
  logic rd_st;
  logic rd_ct;
  logic wr_ct;
  assign rd_st = avs_read && !avs_waitrequest && avs_address == SLDC_OFS_STATUS;
  assign rd_ct = avs_read && !avs_waitrequest && avs_address == SLDC_OFS_CONTROL;
  assign wr_ct = avs_write && !avs_waitrequest && avs_address == SLDC_OFS_CONTROL
    && avs_byteenable[0];
  always_comb begin
    next_on_cnt = '0;
    if (detector_enable) begin
      next_on_cnt = (on_cnt == '1) ? on_cnt : on_cnt + 1'b1;
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      on_cnt <= '0;
    end else begin
      on_cnt <= next_on_cnt;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // margins of 4 cycles absorb the enable and settle-entry latency
  AST_ONE_WAIT: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait state");
  AST_RSV_ZERO: assert property (
    avs_read && !avs_waitrequest |-> avs_readdata[31:4] == '0)
    else $error("reserved");
  AST_CTL_READ: assert property (
    rd_ct |-> avs_readdata[3:0] == {threshold_range_select, threshold_trim})
    else $error("ctl read");
  AST_CTL_WRITE: assert property (
    wr_ct |=> {threshold_range_select, threshold_trim} == $past(avs_writedata[3:0]))
    else $error("ctl write");
  AST_STA_READ: assert property (
    rd_st |-> !avs_readdata[3] && avs_readdata[0] == detector_enable)
    else $error("sta read");
  AST_OFF_CLEAR: assert property (
    rd_st && !detector_enable |-> avs_readdata[2:1] == 2'b00)
    else $error("off");
  AST_EARLY_VALID: assert property (
    rd_st && avs_readdata[1] |-> on_cnt >= SETTLE_CYC - 4)
    else $error("early");
  AST_LATE_VALID: assert property (
    rd_st && on_cnt >= SETTLE_CYC + 4 |-> avs_readdata[1])
    else $error("late");
  AST_IRQ_CAUSE: assert property (
    $rose(low_supply_irq) |-> $past(avs_write)
      || (detector_enable && on_cnt >= SETTLE_CYC - 4))
    else $error("irq");
  cover property (rd_st && avs_readdata[1]);
  cover property ($rose(low_supply_irq));
  cover property (wr_ct);
endmodule
bind sldc_top sldc_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .detector_enable(detector_enable),
  .threshold_trim(threshold_trim), .threshold_range_select(threshold_range_select),
  .low_supply_irq(low_supply_irq));

// File: sim/sldc_tb_top.sv
// testbench: register, settling and interrupt sequences
`timescale 1ns/1ps
module sldc_tb_top;
  import sldc_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic below_threshold_flag = 1'b0;
  logic detector_enable;
  logic [2:0] threshold_trim;
  logic threshold_range_select;
  logic low_supply_irq;
  logic [31:0] rdv;
  int err_total = 0;
  int total_checks = 0;
  // settling shortened so the run stays short; the design default is the full interval
  localparam int TB_SETTLE_CYC = 2000;
  sldc_top #(.SETTLE_CYC(TB_SETTLE_CYC)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .below_threshold_flag(below_threshold_flag),
    .detector_enable(detector_enable), .threshold_trim(threshold_trim),
    .threshold_range_select(threshold_range_select), .low_supply_irq(low_supply_irq));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic complete_run();
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // ----
  // bus cycle: hold until waitrequest is sampled low
  // ----
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  task automatic pulse_flag();
    below_threshold_flag <= 1'b0;
    repeat (4) @(posedge ref_clk);
    below_threshold_flag <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 16; i += 4) rdchk(i[3:0], 32'h0);
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, SLDC_OFS_CONTROL, 32'hf0 | i);
      rdchk(SLDC_OFS_CONTROL, i);
      chk({28'h0, threshold_range_select, threshold_trim}, i);
    end
    avs_byteenable <= 4'he;
    xfer(1'b1, SLDC_OFS_CONTROL, 32'h5);
    avs_byteenable <= 4'hf;
    rdchk(SLDC_OFS_CONTROL, 32'hf);
    rdchk(4'h2, 32'h0);
    xfer(1'b1, SLDC_OFS_STATUS, 32'hff);
    rdchk(SLDC_OFS_STATUS, 32'h1);
    repeat (1000) @(posedge ref_clk);
    xfer(1'b1, SLDC_OFS_STATUS, 32'h0);
    xfer(1'b1, SLDC_OFS_STATUS, 32'h1);
    repeat (TB_SETTLE_CYC - 50) @(posedge ref_clk);
    rdchk(SLDC_OFS_STATUS, 32'h1);
    repeat (100) @(posedge ref_clk);
    rdchk(SLDC_OFS_STATUS, 32'h3);
    xfer(1'b1, SLDC_OFS_IRQ_MASK, 32'h1);
    pulse_flag();
    chk({31'h0, low_supply_irq}, 32'h1);
    rdchk(SLDC_OFS_STATUS, 32'h7);
    xfer(1'b1, SLDC_OFS_IRQ_STATUS, 32'h1);
    xfer(1'b1, SLDC_OFS_IRQ_MASK, 32'h0);
    rdchk(SLDC_OFS_IRQ_STATUS, 32'h0);
    pulse_flag();
    chk({31'h0, low_supply_irq}, 32'h0);
    rdchk(SLDC_OFS_IRQ_STATUS, 32'h1);
    xfer(1'b1, SLDC_OFS_IRQ_MASK, 32'h1);
    rdchk(SLDC_OFS_IRQ_MASK, 32'h1);
    chk({31'h0, low_supply_irq}, 32'h1);
    xfer(1'b1, SLDC_OFS_IRQ_STATUS, 32'h1);
    xfer(1'b1, SLDC_OFS_STATUS, 32'h0);
    rdchk(SLDC_OFS_STATUS, 32'h0);
    pulse_flag();
    rdchk(SLDC_OFS_IRQ_STATUS, 32'h0);
    chk({31'h0, low_supply_irq}, 32'h0);
    complete_run();
  end
  // one settling interval plus generous slack for the register traffic
  initial begin
    repeat (TB_SETTLE_CYC + 20000) @(posedge ref_clk);
    err_total++;
    complete_run();
  end
endmodule
